/* File: hw/alr_cap_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module alr_cap_regs #(
    parameter bit UPSTREAM_PORT = 1'b0
) (
    // Clock, reset and clock enable
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         ce,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [alr_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output var  logic [31:0]                  prdata,
    output var  logic                         pready,
    output var  logic                         pslverr,
    // Peer-to-peer egress check
    input  wire alr_pkg::alr_p2p_req_t        p2p_req,
    output var  alr_pkg::alr_p2p_dec_t        p2p_dec,
    // Settings seen by the port logic
    output var  alr_pkg::alr_acs_ctl_t        acs_ctl,
    output var  alr_pkg::alr_ltr_ctl_t        ltr_ctl,
    output var  alr_pkg::alr_ltr_lim_t        ltr_lim
);
    // All state of this module
    typedef struct packed {
        alr_pkg::alr_acs_ctl_t acs;
        alr_pkg::alr_ltr_ctl_t ltr;
        logic [31:0]           rdata;
    } alr_state_t;

    alr_state_t  state_reg;
    alr_state_t  state_next;

    localparam bit ACS_ON = !UPSTREAM_PORT;
    localparam bit LTR_ON = UPSTREAM_PORT;

    // Address decode
    logic        sel_acs_hdr;
    logic        sel_acs_cap;
    logic        sel_egress;
    logic        sel_ltr_hdr;
    logic        sel_snoop;
    logic        mapped;
    logic        setup_ph;
    logic        access_ph;
    logic        wr_go;
    logic [31:0] rd_word;
    logic [31:0] cap_word;
    logic [31:0] egr_word;
    logic [31:0] snp_word;
    logic [31:0] acs_hdr_word;
    logic [31:0] ltr_hdr_word;
    logic [31:0] byte_mask;

    // Byte lanes under the write strobes
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_lane
            assign byte_mask[8*g +: 8] = {8{pstrb[g]}};
        end
    endgenerate

    // Only the port flavour that owns a structure decodes it
    always_comb
    begin
        sel_acs_hdr = ACS_ON && (paddr == alr_pkg::ACS_HDR_OFS);
        sel_acs_cap = ACS_ON && (paddr == alr_pkg::ACS_CAP_OFS);
        sel_egress  = ACS_ON && (paddr == alr_pkg::EGRESS_OFS);
        sel_ltr_hdr = LTR_ON && (paddr == alr_pkg::LTR_HDR_OFS);
        sel_snoop   = LTR_ON && (paddr == alr_pkg::SNOOP_OFS);
        mapped      = sel_acs_hdr || sel_acs_cap || sel_egress
                      || sel_ltr_hdr || sel_snoop;
    end

    // Bus phases; writes land only at the access edge
    always_comb
    begin
        setup_ph  = psel && !penable;
        access_ph = psel && penable;
        wr_go     = ce && access_ph && pwrite && mapped;
    end

    // Fixed header words
    always_comb
    begin
        acs_hdr_word        = alr_pkg::WORD_ZERO;
        acs_hdr_word[15:0]  = alr_pkg::ACS_CAP_ID;
        acs_hdr_word[19:16] = alr_pkg::CAP_VERSION;
        acs_hdr_word[31:20] = alr_pkg::NEXT_CAP_PTR;
        ltr_hdr_word        = alr_pkg::WORD_ZERO;
        ltr_hdr_word[15:0]  = alr_pkg::LTR_CAP_ID;
        ltr_hdr_word[19:16] = alr_pkg::CAP_VERSION;
        ltr_hdr_word[31:20] = alr_pkg::NEXT_CAP_PTR;
    end

    // Capability word: fixed ones, vector size, then live enables
    always_comb
    begin
        cap_word = alr_pkg::WORD_ZERO;
        cap_word[alr_pkg::ACS_FEAT_N-1:0] = alr_pkg::ACS_IMPL_BITS;
        cap_word[alr_pkg::ACS_SIZE_LSB +: 8] = alr_pkg::EGRESS_VEC_SZ;
        cap_word[alr_pkg::ACS_EN_LSB +: alr_pkg::ACS_FEAT_N] =
            state_reg.acs.enable;
    end

    // Vector and latency words, reserved bits read zero
    always_comb
    begin
        egr_word      = alr_pkg::WORD_ZERO;
        egr_word[7:0] = state_reg.acs.egress;
        snp_word      = alr_pkg::WORD_ZERO;
        snp_word[alr_pkg::SNOOP_VAL_LSB +: 10] = state_reg.ltr.value;
        snp_word[alr_pkg::SNOOP_SCL_LSB +: 3]  = state_reg.ltr.scale;
    end

    // Read mux; unmapped words read zero
    always_comb
    begin
        rd_word = alr_pkg::WORD_ZERO;
        if (sel_acs_hdr)
        begin
            rd_word = acs_hdr_word;
        end
        else if (sel_acs_cap)
        begin
            rd_word = cap_word;
        end
        else if (sel_egress)
        begin
            rd_word = egr_word;
        end
        else if (sel_ltr_hdr)
        begin
            rd_word = ltr_hdr_word;
        end
        else if (sel_snoop)
        begin
            rd_word = snp_word;
        end
    end

    // Next state: read data captured in setup so prdata is a flop
    // Limitation: ce must stay high through a read setup cycle, or the access returns stale data
    always_comb
    begin
        logic [31:0] merged;
        merged     = alr_pkg::WORD_ZERO;
        state_next = state_reg;
        if (ce && setup_ph && !pwrite)
        begin
            state_next.rdata = rd_word;
        end
        if (wr_go && sel_acs_cap)
        begin
            merged = (cap_word & ~byte_mask) | (pwdata & byte_mask);
            state_next.acs.enable =
                merged[alr_pkg::ACS_EN_LSB +: alr_pkg::ACS_FEAT_N];
        end
        if (wr_go && sel_egress)
        begin
            merged = (egr_word & ~byte_mask) | (pwdata & byte_mask);
            state_next.acs.egress = merged[7:0];
        end
        if (wr_go && sel_snoop)
        begin
            merged = (snp_word & ~byte_mask) | (pwdata & byte_mask);
            state_next.ltr.value = merged[alr_pkg::SNOOP_VAL_LSB +: 10];
            state_next.ltr.scale = merged[alr_pkg::SNOOP_SCL_LSB +: 3];
        end
    end

    // State register; reset values are the documented defaults
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg            <= '0;
            state_reg.acs.enable <= alr_pkg::ACS_EN_RST;
            state_reg.acs.egress <= alr_pkg::EGRESS_RST;
            state_reg.ltr.value  <= alr_pkg::SNOOP_VAL_RST;
            state_reg.ltr.scale  <= alr_pkg::SNOOP_SCL_RST;
            state_reg.rdata      <= alr_pkg::WORD_ZERO;
        end
        else if (ce)
        begin
            state_reg <= state_next;
        end
    end

    // Bus answer: one wait-free access phase; frozen while ce is low
    always_comb
    begin
        pready  = ce && access_ph;
        pslverr = ce && access_ph && !mapped;
        prdata  = state_reg.rdata;
    end

    // Settings driven out; absent structures stay at reset
    always_comb
    begin
        acs_ctl = ACS_ON ? state_reg.acs : '0;
        ltr_ctl = LTR_ON ? state_reg.ltr : '0;
    end

    // Egress decision for peer traffic
    alr_egress_check #(
        .ACS_PRESENT (ACS_ON)
    ) u_egress (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .ctl     (acs_ctl),
        .req     (p2p_req),
        .dec     (p2p_dec)
    );

    // Latency limit in nanoseconds
    alr_latency_calc u_latency (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .ltr     (ltr_ctl),
        .lim     (ltr_lim)
    );
endmodule : alr_cap_regs
`default_nettype wire

/* File: hw/alr_pkg.sv */
`default_nettype none
package alr_pkg;
    // Register word offsets on the configuration bus
    localparam int                ADDR_W         = 12;
    localparam logic [ADDR_W-1:0] ACS_HDR_OFS    = 12'h0220;
    localparam logic [ADDR_W-1:0] ACS_CAP_OFS    = 12'h0224;
    localparam logic [ADDR_W-1:0] EGRESS_OFS     = 12'h0228;
    localparam logic [ADDR_W-1:0] LTR_HDR_OFS    = 12'h0230;
    localparam logic [ADDR_W-1:0] SNOOP_OFS      = 12'h0234;

    // Extended capability header fields
    localparam logic [15:0]       ACS_CAP_ID     = 16'h000D;
    localparam logic [15:0]       LTR_CAP_ID     = 16'h0018;
    localparam logic [3:0]        CAP_VERSION    = 4'h1;
    localparam logic [11:0]       NEXT_CAP_PTR   = 12'h000;

    // Access-control capability layout
    localparam int                ACS_FEAT_N     = 7;
    localparam logic [6:0]        ACS_IMPL_BITS  = 7'h7F;
    localparam logic [7:0]        EGRESS_VEC_SZ  = 8'h08;
    localparam int                ACS_SIZE_LSB   = 8;
    localparam int                ACS_EN_LSB     = 16;
    localparam logic [6:0]        ACS_EN_RST     = 7'h00;
    localparam logic [7:0]        EGRESS_RST     = 8'h00;

    // Feature index within the implemented and enable groups
    localparam int                FEAT_SRC_VAL   = 0;
    localparam int                FEAT_TRANS_BLK = 1;
    localparam int                FEAT_REQ_RDR   = 2;
    localparam int                FEAT_CPL_RDR   = 3;
    localparam int                FEAT_UP_FWD    = 4;
    localparam int                FEAT_EGRESS    = 5;
    localparam int                FEAT_DIRECT    = 6;

    // Latency register layout and encoding
    localparam int                SNOOP_VAL_LSB  = 0;
    localparam int                SNOOP_SCL_LSB  = 10;
    localparam logic [9:0]        SNOOP_VAL_RST  = 10'h000;
    localparam logic [2:0]        SNOOP_SCL_RST  = 3'h0;
    localparam logic [2:0]        LTR_SCALE_MAX  = 3'h5;
    localparam int                LTR_UNIT_SHIFT = 5;
    localparam int                LTR_LIMIT_W    = 35;

    localparam logic [31:0]       WORD_ZERO      = 32'h0000_0000;

    // Software-written access-control settings
    typedef struct packed {
        logic [6:0] enable;
        logic [7:0] egress;
    } alr_acs_ctl_t;

    // Software-written latency limit
    typedef struct packed {
        logic [2:0] scale;
        logic [9:0] value;
    } alr_ltr_ctl_t;

    // Peer-to-peer request offered for an egress check
    typedef struct packed {
        logic       valid;
        logic       p2p;
        logic [2:0] target;
    } alr_p2p_req_t;

    // Egress decision for that request
    typedef struct packed {
        logic       valid;
        logic       pass;
        logic       redirect;
        logic       block;
        logic       violation;
    } alr_p2p_dec_t;

    // Latency limit in nanoseconds
    typedef struct packed {
        logic [LTR_LIMIT_W-1:0] limit_ns;
        logic                   invalid;
    } alr_ltr_lim_t;
endpackage : alr_pkg
`default_nettype wire

/* File: hw/alr_egress_check.sv */
`timescale 1ns/1ps
`default_nettype none
module alr_egress_check #(
    parameter bit ACS_PRESENT = 1'b1
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    // Settings and request
    input  wire alr_pkg::alr_acs_ctl_t ctl,
    input  wire alr_pkg::alr_p2p_req_t req,
    // Registered decision
    output var  alr_pkg::alr_p2p_dec_t dec
);
    alr_pkg::alr_p2p_dec_t state_reg;
    alr_pkg::alr_p2p_dec_t state_next;
    logic                  hit;

    // Vector bit of the target port, only when egress control is on
    always_comb
    begin
        hit = ACS_PRESENT && req.p2p && ctl.enable[alr_pkg::FEAT_EGRESS]
              && ctl.egress[req.target];
        state_next           = '0;
        state_next.valid     = req.valid;
        state_next.redirect  = hit && ctl.enable[alr_pkg::FEAT_REQ_RDR];
        state_next.block     = hit && !ctl.enable[alr_pkg::FEAT_REQ_RDR];
        state_next.violation = state_next.block;
        state_next.pass      = !hit;
        if (!req.valid)
        begin
            state_next = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '0;
        end
        else if (ce)
        begin
            state_reg <= state_next;
        end
    end

    assign dec = state_reg;
endmodule : alr_egress_check
`default_nettype wire

/* File: hw/alr_latency_calc.sv */
`timescale 1ns/1ps
`default_nettype none
module alr_latency_calc (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    // Latency setting
    input  wire alr_pkg::alr_ltr_ctl_t ltr,
    // Registered limit
    output var  alr_pkg::alr_ltr_lim_t lim
);
    alr_pkg::alr_ltr_lim_t state_reg;
    alr_pkg::alr_ltr_lim_t state_next;

    // Each scale step multiplies by 32; codes above five are refused
    always_comb
    begin
        state_next          = '0;
        state_next.limit_ns = alr_pkg::LTR_LIMIT_W'(ltr.value);
        for (int i = 0; i < int'(alr_pkg::LTR_SCALE_MAX); i++)
        begin
            if (3'(i) < ltr.scale)
            begin
                state_next.limit_ns = state_next.limit_ns << alr_pkg::LTR_UNIT_SHIFT;
            end
        end
        if (ltr.scale > alr_pkg::LTR_SCALE_MAX)
        begin
            state_next.limit_ns = '0;
            state_next.invalid  = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '0;
        end
        else if (ce)
        begin
            state_reg <= state_next;
        end
    end

    assign lim = state_reg;
endmodule : alr_latency_calc
`default_nettype wire

/* File: verification/alr_cap_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module alr_cap_regs_monitor #(
    parameter bit UPSTREAM_PORT = 1'b0
) (
    // Clock, reset and enable
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        ce,
    // APB slave side
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [alr_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    input  wire logic                        pready,
    input  wire logic                        pslverr,
    // Egress check and settings
    input  wire alr_pkg::alr_p2p_req_t       p2p_req,
    input  wire alr_pkg::alr_p2p_dec_t       p2p_dec,
    input  wire alr_pkg::alr_acs_ctl_t       acs_ctl,
    input  wire alr_pkg::alr_ltr_ctl_t       ltr_ctl,
    input  wire alr_pkg::alr_ltr_lim_t       ltr_lim
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Write completing this cycle, and a vector hit on the offered request
    logic wr_done;
    logic hit;
    assign wr_done = ce && psel && penable && pwrite;
    assign hit     = p2p_req.p2p && acs_ctl.enable[5] && acs_ctl.egress[p2p_req.target];

    chk_zero_wait: assert property (pready == (ce && psel && penable))
        else $error("pready not in the access cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside a completed access");
    chk_dec_latency: assert property ((ce && p2p_req.valid) |=> p2p_dec.valid)
        else $error("egress decision late or missing");
    chk_redirect_hit: assert property ((ce && p2p_req.valid && hit && acs_ctl.enable[2])
        |=> (p2p_dec.redirect && !p2p_dec.block && !p2p_dec.pass)) else $error("hit not redirected");
    chk_block_hit: assert property ((ce && p2p_req.valid && hit && !acs_ctl.enable[2])
        |=> (p2p_dec.block && p2p_dec.violation && !p2p_dec.redirect)) else $error("hit not blocked");
    chk_pass_miss: assert property ((ce && p2p_req.valid && !hit)
        |=> (p2p_dec.pass && !p2p_dec.block && !p2p_dec.redirect)) else $error("miss not passed");
    chk_port_flavour: assert property (UPSTREAM_PORT ? (acs_ctl == '0) : (ltr_ctl == '0))
        else $error("settings of an absent structure");
    chk_enable_write: assert property ((wr_done && !UPSTREAM_PORT && paddr == alr_pkg::ACS_CAP_OFS
        && pstrb[2]) |=> (acs_ctl.enable == $past(pwdata[22:16]))) else $error("enables not written");
    chk_snoop_write: assert property ((wr_done && UPSTREAM_PORT && paddr == alr_pkg::SNOOP_OFS
        && pstrb[1:0] == 2'h3) |=> (ltr_ctl == $past(pwdata[12:0]))) else $error("latency not written");
    chk_limit_calc: assert property ((ce && ltr_ctl.scale <= 3'h5) |=> (!ltr_lim.invalid
        && ltr_lim.limit_ns == (35'($past(ltr_ctl.value)) << (5 * $past(ltr_ctl.scale)))))
        else $error("latency limit wrong");
    chk_scale_refused: assert property ((ce && ltr_ctl.scale > 3'h5)
        |=> (ltr_lim.invalid && ltr_lim.limit_ns == '0)) else $error("bad scale accepted");
endmodule : alr_cap_regs_monitor
`default_nettype wire

/* File: verification/alr_cap_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module alr_cap_regs_tb;
    localparam logic [32:0] OK_W  = 33'h0_0000_0000;
    localparam logic [32:0] ERR_W = 33'h1_0000_0000;
    logic                  pclk    = 1'b0;
    logic                  presetn = 1'b0;
    logic                  psel_dn = 1'b0;
    logic                  psel_up = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite  = 1'b0;
    logic [11:0]           paddr   = 12'h000;
    logic [31:0]           pwdata  = 32'h0000_0000;
    logic [3:0]            pstrb   = 4'hF;
    logic [31:0]           rd_dn, rd_up, w;
    logic                  rdy_dn, rdy_up, err_dn, err_up;
    alr_pkg::alr_p2p_req_t req     = '0;
    alr_pkg::alr_p2p_dec_t dec;
    logic [32:0]           apb_q[$];
    alr_pkg::alr_p2p_dec_t dec_q[$];
    alr_pkg::alr_ltr_lim_t lim;
    alr_pkg::alr_ltr_lim_t lim_q[$];
    logic                  ce      = 1'b1;
    logic [6:0]            en;
    logic [7:0]            eg;
    int                    err_total  = 0;
    int                    num_checks = 0;
    int                    cycles     = 0;

    always #4 pclk = ~pclk;

    // Downstream and upstream builds on separate selects
    alr_cap_regs #(.UPSTREAM_PORT(1'b0)) u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel_dn),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(rd_dn),
        .pready(rdy_dn), .pslverr(err_dn), .p2p_req(req), .p2p_dec(dec), .acs_ctl(), .ltr_ctl(), .ltr_lim());
    alr_cap_regs #(.UPSTREAM_PORT(1'b1)) u_up (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel_up),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(rd_up),
        .pready(rdy_up), .pslverr(err_up), .p2p_req(req), .p2p_dec(), .acs_ctl(), .ltr_ctl(), .ltr_lim(lim));

    task automatic cmp_apb(input logic [32:0] e, input logic [32:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp_apb

    task automatic cmp_dec(input alr_pkg::alr_p2p_dec_t e, input alr_pkg::alr_p2p_dec_t g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp_dec

    task automatic cmp_lim(input alr_pkg::alr_ltr_lim_t e, input alr_pkg::alr_ltr_lim_t g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp_lim

    // Limit expected from a latency register word: value times 32 per scale step
    function automatic alr_pkg::alr_ltr_lim_t exp_lim(input logic [12:0] r);
        exp_lim = '0;
        if (r[12:10] > 3'h5)
            exp_lim.invalid = 1'b1;
        else
            exp_lim.limit_ns = 35'(r[9:0]) << (5 * r[12:10]);
    endfunction : exp_lim

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    // Psel stays up at the end so a next setup may follow at once
    task automatic apb(input logic up, input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [32:0] e);
        psel_dn <= !up;
        psel_up <= up;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        apb_q.push_back(e);
        if (up && !wr && a == alr_pkg::SNOOP_OFS)
            lim_q.push_back(exp_lim(e[12:0]));
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!(up ? rdy_up : rdy_dn))
            @(posedge pclk);
        penable <= 1'b0;
    endtask : apb

    task automatic idle();
        psel_dn <= 1'b0;
        psel_up <= 1'b0;
        @(posedge pclk);
    endtask : idle

    task automatic p2p(input logic [2:0] t);
        logic                  pp;
        logic                  hit;
        alr_pkg::alr_p2p_dec_t d;
        pp  = ($urandom_range(3) != 0);
        hit = pp && en[5] && eg[t];
        d   = {1'b1, !hit, hit && en[2], hit && !en[2], hit && !en[2]};
        req <= {1'b1, pp, t};
        dec_q.push_back(d);
        @(posedge pclk);
    endtask : p2p

    // Completed transfers and decisions against the oldest note
    always @(posedge pclk)
    begin
        if (penable && psel_up && rdy_up)
            cmp_apb(apb_q.pop_front(), {err_up, pwrite ? 32'h0000_0000 : rd_up});
        if (penable && psel_up && rdy_up && !pwrite && paddr == alr_pkg::SNOOP_OFS)
            cmp_lim(lim_q.pop_front(), lim);
        if (penable && psel_dn && rdy_dn)
            cmp_apb(apb_q.pop_front(), {err_dn, pwrite ? 32'h0000_0000 : rd_dn});
        if (dec.valid)
            cmp_dec(dec_q.pop_front(), dec);
    end

    // A hang ends the run as a failure
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            err_total++;
            end_of_test();
        end
    end

    initial
    begin
        void'($urandom(32'h82fa));
        w = 32'h0000_0000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, and each build refusing the other's structure
        apb(0, 0, alr_pkg::ACS_HDR_OFS, w, 4'hF, 33'h0_0001_000D);
        apb(0, 0, alr_pkg::ACS_CAP_OFS, w, 4'hF, 33'h0_0000_087F);
        apb(0, 0, alr_pkg::EGRESS_OFS, w, 4'hF, OK_W);
        apb(0, 0, alr_pkg::SNOOP_OFS, w, 4'hF, ERR_W);
        apb(1, 0, alr_pkg::LTR_HDR_OFS, w, 4'hF, 33'h0_0001_0018);
        apb(1, 0, alr_pkg::SNOOP_OFS, w, 4'hF, OK_W);
        apb(1, 0, alr_pkg::EGRESS_OFS, w, 4'hF, ERR_W);
        idle();
        $display("test reset values done");
        // Writable bits follow data and strobes, fixed bits ignore writes
        repeat (4)
        begin
            w = $urandom();
            apb(0, 1, alr_pkg::ACS_CAP_OFS, w, 4'hF, OK_W);
            apb(0, 1, alr_pkg::ACS_CAP_OFS, ~w, 4'h3, OK_W);
            apb(0, 0, alr_pkg::ACS_CAP_OFS, w, 4'hF, {1'b0, 32'h0000_087F | (w & 32'h007F_0000)});
            apb(0, 1, alr_pkg::EGRESS_OFS, w, 4'hF, OK_W);
            apb(0, 1, alr_pkg::ACS_HDR_OFS, w, 4'hF, OK_W);
            apb(0, 1, 12'h22C, w, 4'hF, ERR_W);
            apb(0, 0, alr_pkg::EGRESS_OFS, w, 4'hF, {1'b0, w & 32'h0000_00FF});
            apb(0, 0, alr_pkg::ACS_HDR_OFS, w, 4'hF, 33'h0_0001_000D);
            apb(1, 1, alr_pkg::SNOOP_OFS, w, 4'hF, OK_W);
            apb(1, 1, alr_pkg::LTR_HDR_OFS, w, 4'hF, OK_W);
            apb(1, 0, alr_pkg::SNOOP_OFS, w, 4'hF, {1'b0, w & 32'h0000_1FFF});
            apb(1, 0, alr_pkg::LTR_HDR_OFS, w, 4'hF, 33'h0_0001_0018);
        end
        idle();
        $display("test register access done");
        // Every target port: block, redirect, then egress control off
        for (int m = 0; m < 3; m++)
        begin
            en = (7'($urandom()) & 7'h5B) | (m == 1 ? 7'h04 : 7'h00) | (m < 2 ? 7'h20 : 7'h00);
            eg = 8'($urandom());
            apb(0, 1, alr_pkg::ACS_CAP_OFS, {9'h000, en, 16'h0000}, 4'hF, OK_W);
            apb(0, 1, alr_pkg::EGRESS_OFS, {24'h00_0000, eg}, 4'hF, OK_W);
            idle();
            for (int t = 0; t < 8; t++)
                p2p(3'(t));
            req <= '0;
            repeat (2) @(posedge pclk);
        end
        // Low clock enable freezes the check: the request held while ce is low gives no decision, and the next one is decided once ce returns
        ce  <= 1'b0;
        req <= {1'b1, 1'b1, 3'h0};
        repeat (3) @(posedge pclk);
        ce  <= 1'b1;
        p2p(3'h0);
        req <= '0;
        repeat (2) @(posedge pclk);
        $display("test egress decisions done");
        // Every scale code, the refused ones included
        for (int s = 0; s < 8; s++)
        begin
            w = {19'h0_0000, 3'(s), 10'($urandom())};
            apb(1, 1, alr_pkg::SNOOP_OFS, w, 4'hF, OK_W);
            apb(1, 0, alr_pkg::SNOOP_OFS, w, 4'hF, {1'b0, w});
        end
        idle();
        repeat (4) @(posedge pclk);
        $display("test latency scale done");
        end_of_test();
    end
endmodule : alr_cap_regs_tb

bind alr_cap_regs alr_cap_regs_monitor #(.UPSTREAM_PORT(UPSTREAM_PORT)) u_mon (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .p2p_req(p2p_req), .p2p_dec(p2p_dec), .acs_ctl(acs_ctl),
    .ltr_ctl(ltr_ctl), .ltr_lim(ltr_lim));
`default_nettype wire
